// ==== dv/cesrk_host_model.sv ====
`timescale 1ns/1ps
// **********
// network host model on the register bus
// **********
module cesrk_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_ack,
    input  wire logic [31:0] i_dat,
    output logic             o_cyc,
    output logic             o_stb,
    output logic             o_we,
    output logic      [7:0]  o_adr,
    output logic      [3:0]  o_sel,
    output logic      [31:0] o_dat
);
    initial begin
        {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
    end
    // request held until ack; no latency assumed, bounded wait only
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output bit ok);
        ok = 1'b0;
        r = 32'h0;
        @(posedge i_clk);
        {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'h3, w, a, 4'hF, d};
        repeat (16) begin
            @(posedge i_clk);
            if (i_ack === 1'b1 && !ok) begin
                r = i_dat;
                ok = 1'b1;
            end
            if (ok) break;
        end
        {o_cyc, o_stb, o_dat} <= {2'h0, ~d};
        @(posedge i_clk);
    endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
    // **********
    // bench
    // **********
    typedef struct {logic [16:0] f; logic [31:0] e;} cesrk_row_type;
    logic clk, rst_b, ack, evt, cfg, key_b, rdn, grn, red, green, rs, dflt, placed;
    logic cyc, stb, we;
    logic [31:0] rdat, q, wdat;
    logic [16:0] flg;
    logic [7:0]  adr;
    logic [6:0]  cnt, slot;
    logic [5:0]  id;
    logic [3:0]  sel;
    int          fails, checks, n, tog;
    bit          ok;
    cesrk_row_type rows [17];
    cesrk_top #(.LONG_PRESS_CYC(20), .FLASH_HALF_CYC(4)) dut (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_reset_key_b(key_b), .i_sys_red_normal(rdn), .i_sys_green_normal(grn),
        .o_system_indicator_red(red), .o_system_indicator_green(green),
        .o_module_restart(rs), .o_restore_defaults(dflt),
        .i_first_boot_flag(flg[0]), .i_memory_oversize_flag(flg[1]),
        .i_checksum_fault_flag(flg[2]), .i_boot_fail_flag(flg[3]),
        .i_load_power_missing_flag(flg[4]), .i_overload_flag(flg[5]),
        .i_converter_read_fault_flag(flg[6]), .i_memory_program_fail_flag(flg[7]),
        .i_no_station_record_flag(flg[8]), .i_station_record_mismatch_flag(flg[9]),
        .i_no_station_found_flag(flg[10]), .i_polling_timeout_flag(flg[11]),
        .i_station_fail_flag(flg[12]), .i_length_overrun_flag(flg[13]),
        .i_hotswap_recovery_fail_flag(flg[14]), .i_network_init_fail_flag(flg[15]),
        .i_address_range_fault_flag(flg[16]), .i_slot_timeout_evt(evt),
        .i_slot_timeout_id(id), .i_module_count(cnt), .i_config_done(cfg),
        .o_errmod_placed(placed), .o_errmod_first_slot(slot));
    cesrk_host_model host (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc),
        .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        host.xfer(w, a, d, q, ok);
        if (!ok) begin
            fails++;
            test_done();
        end
    endtask
    // polls one pulse output; a lost pulse ends the run
    task wait_out(input bit w);
        n = 0;
        while ((w ? dflt : rs) !== 1'b1 && n < 64) begin
            @(posedge clk);
            n++;
        end
        if (n >= 64) begin
            fails++;
            test_done();
        end
    endtask
    initial begin
        {rst_b, evt, cfg, rdn, flg, id, cnt} = '0;
        {key_b, grn} = 2'h3;
        foreach (rows[k]) rows[k] = '{17'h1 << k, 32'h2 << k};
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[k]) begin
            @(posedge clk) flg <= rows[k].f;
            @(posedge clk) flg <= '0;
            bus(0, cesrk_pkg::OFS_SYS_FLAGS, 0); chk(q, rows[k].e);
            bus(1, cesrk_pkg::OFS_CLR_SYS, 32'hFFFF_FFFF);
        end
        @(posedge clk) flg <= '1;
        @(posedge clk) flg <= '0;
        bus(1, cesrk_pkg::OFS_SYS_FLAGS, 32'hFFFF_FFFF);
        bus(0, cesrk_pkg::OFS_SYS_FLAGS, 0); chk(q, 32'h0003_FFFE);
        bus(0, cesrk_pkg::OFS_SYS_FLAGS, 0); chk(q, 32'h0003_FFFE);
        bus(1, cesrk_pkg::OFS_CLR_SYS, 32'hFFFF_FFFF);
        bus(0, 8'h40, 0); chk(q, 32'h0);
        cnt <= 7'h40;
        foreach (rows[k]) if (k < 4) begin
            @(posedge clk) {evt, id} <= {1'b1, 6'(k[1] ? 32 + 31 * k[0] : 31 * k[0])};
            @(posedge clk) evt <= 1'b0;
        end
        bus(0, cesrk_pkg::OFS_MAP_LOW, 0); chk(q, 32'h8000_0001);
        bus(0, cesrk_pkg::OFS_MAP_HIGH, 0); chk(q, 32'h8000_0001);
        bus(0, cesrk_pkg::OFS_SYS_FLAGS, 0); chk(q, 32'h0000_1000);
        bus(1, cesrk_pkg::OFS_CLR_LOW, 32'hFFFF_FFFF);
        cnt <= 7'h0A;
        @(posedge clk) {evt, id} <= {1'b1, 6'h0A};
        @(posedge clk) evt <= 1'b0;
        bus(0, cesrk_pkg::OFS_MAP_LOW, 0); chk(q, 32'h0);
        for (int c = 61; c < 64; c++) begin
            @(posedge clk) {cnt, cfg} <= {7'(c + 6 * (c - 61) * (c - 62)), 1'b1};
            @(posedge clk) cfg <= 1'b0;
            repeat (2) @(posedge clk);
            chk({placed, slot}, c == 61 ? 8'hBE : 8'h00);
        end
        @(posedge clk) key_b <= 1'b0;
        repeat (5) @(posedge clk);
        key_b <= 1'b1;
        wait_out(0); chk(dflt, 0);
        @(posedge clk) key_b <= 1'b0;
        repeat (30) @(posedge clk);
        chk({red, green}, 2'b10);
        key_b <= 1'b1;
        wait_out(1); chk(rs, 0);
        tog = 0;
        n = red;
        repeat (40) begin
            @(posedge clk);
            if (red !== n[0]) tog++;
            n = red;
        end
        chk(tog, cesrk_pkg::FLASH_TOGGLES);
        @(posedge clk) {cnt, cfg} <= {7'h05, 1'b1};
        @(posedge clk) cfg <= 1'b0;
        bus(0, cesrk_pkg::OFS_STATUS, 0); chk(q, 32'h0005_0601);
        bus(1, cesrk_pkg::OFS_CLR_HIGH, 32'h0000_0001);
        bus(0, cesrk_pkg::OFS_MAP_HIGH, 0); chk(q, 32'h8000_0000);
        // mid-run reset: everything back to zero, indicators follow the normal drive
        @(posedge clk) {rst_b, rdn} <= 2'b01;
        @(posedge clk);
        chk(rdat, 32'h0);
        chk({placed, slot, rs, dflt, ack, red, green}, 32'h0);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        chk({red, green}, 2'b11);
        bus(0, cesrk_pkg::OFS_MAP_HIGH, 0); chk(q, 32'h0);
        test_done();
    end
endmodule

// ==== verilog/cesrk_pkg.sv ====
package cesrk_pkg;

    // ********************************************************
    // clock and timing
    // ********************************************************
    localparam longint unsigned CLK_FREQ_HZ    = 200_000_000;
    localparam longint unsigned LONG_PRESS_MS  = 6000;
    localparam longint unsigned FLASH_HALF_MS  = 250;
    localparam int unsigned     LONG_PRESS_CYC =
        int'((LONG_PRESS_MS * CLK_FREQ_HZ) / 64'd1000);
    localparam int unsigned     FLASH_HALF_CYC =
        int'((FLASH_HALF_MS * CLK_FREQ_HZ) / 64'd1000);
    localparam int unsigned     TIMER_W        = 31;
    localparam logic [7:0]      FLASH_TOGGLES  = 8'h06;

    // ********************************************************
    // register map, byte addresses
    // ********************************************************
    localparam int unsigned ADR_W          = 8;
    localparam logic [7:0]  OFS_SYS_FLAGS  = 8'h00;
    localparam logic [7:0]  OFS_MAP_LOW    = 8'h04;
    localparam logic [7:0]  OFS_MAP_HIGH   = 8'h08;
    localparam logic [7:0]  OFS_STATUS     = 8'h0C;
    localparam logic [7:0]  OFS_CLR_SYS    = 8'h10;
    localparam logic [7:0]  OFS_CLR_LOW    = 8'h14;
    localparam logic [7:0]  OFS_CLR_HIGH   = 8'h18;

    // ********************************************************
    // system fault word layout
    // ********************************************************
    localparam logic [31:0] SYS_VALID_MASK  = 32'h0003_FFFE;
    localparam logic [31:0] FLAGS_RESET     = 32'h0000_0000;
    localparam int unsigned BIT_FIRST_BOOT  = 1;
    localparam int unsigned BIT_MEM_OVER    = 2;
    localparam int unsigned BIT_CHECKSUM    = 3;
    localparam int unsigned BIT_BOOT_FAIL   = 4;
    localparam int unsigned BIT_LOAD_PWR    = 5;
    localparam int unsigned BIT_OVERLOAD    = 6;
    localparam int unsigned BIT_CONV_READ   = 7;
    localparam int unsigned BIT_MEM_PROG    = 8;
    localparam int unsigned BIT_NO_RECORD   = 9;
    localparam int unsigned BIT_REC_DIFF    = 10;
    localparam int unsigned BIT_NO_STATION  = 11;
    localparam int unsigned BIT_POLL_TOUT   = 12;
    localparam int unsigned BIT_STN_FAIL    = 13;
    localparam int unsigned BIT_LEN_OVER    = 14;
    localparam int unsigned BIT_HOTSWAP     = 15;
    localparam int unsigned BIT_NET_INIT    = 16;
    localparam int unsigned BIT_ADR_RANGE   = 17;

    // ********************************************************
    // module stack and status word layout
    // ********************************************************
    localparam logic [6:0]  MAX_MODULES     = 7'h40;
    localparam logic [6:0]  ERRMOD_SLOTS    = 7'h03;
    localparam logic [6:0]  ERRMOD_LAST_OK  = 7'h3D;
    localparam int unsigned STAT_PLACED_BIT = 0;
    localparam int unsigned STAT_SLOT_LSB   = 8;
    localparam int unsigned STAT_COUNT_LSB  = 16;
    localparam int unsigned STAT_KEY_LSB    = 24;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_SHORT,
        KEY_LONG,
        KEY_FLASH
    } cesrk_key_type;

endpackage

// ==== verilog/cesrk_top.sv ====
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// RULE1: time button hold; under six seconds restarts, longer restores defaults
// RULE2: once held six seconds, indicator goes steady red, green off
// RULE3: after release from long press, indicator flashes red
// RULE4: at configuration done, place error module right after last physical module
// RULE5: with fewer than three free slots, skip placement silently
// RULE6: system word is 32 bits; bit 0 and bits 18 to 31 reserved
// RULE7: bit 1 set on first boot with empty memory
// RULE8: bit 2 set when stored data exceeds planned memory size
// RULE9: bit 3 set on stored data checksum failure
// RULE10: bit 4 set when coupler or module fails to boot
// RULE11: bits 5, 6, 7 flag load power, overload, converter read faults
// RULE12: bit 8 set when memory write or erase fails
// RULE13: bits 9, 10, 11 flag station record missing, differing, none found
// RULE14: bit 12 set on polling communication timeout
// RULE15: bit 13 set on station failure
// RULE16: bit 14 set when operating data length exceeds configured value
// RULE17: bit 15 set when hot-swap recovery fails
// RULE18: bit 16 set when network initialization fails
// RULE19: bit 17 set when register address leaves controlled range
// RULE20: low map bit n-1 set on timeout of module n, 1 to 32
// RULE21: high map bit n-33 set on timeout of module n, 33 to 64
// RULE22: at most 64 modules; timeouts beyond the stack are ignored
// RULE23: reserved bits read zero; reads never change any flag
module cesrk_top #(
    parameter int unsigned LONG_PRESS_CYC = cesrk_pkg::LONG_PRESS_CYC,
    parameter int unsigned FLASH_HALF_CYC = cesrk_pkg::FLASH_HALF_CYC
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_reset_key_b,
    input  wire logic        i_sys_red_normal,
    input  wire logic        i_sys_green_normal,
    output logic             o_system_indicator_red,
    output logic             o_system_indicator_green,
    output logic             o_module_restart,
    output logic             o_restore_defaults,
    input  wire logic        i_first_boot_flag,
    input  wire logic        i_memory_oversize_flag,
    input  wire logic        i_checksum_fault_flag,
    input  wire logic        i_boot_fail_flag,
    input  wire logic        i_load_power_missing_flag,
    input  wire logic        i_overload_flag,
    input  wire logic        i_converter_read_fault_flag,
    input  wire logic        i_memory_program_fail_flag,
    input  wire logic        i_no_station_record_flag,
    input  wire logic        i_station_record_mismatch_flag,
    input  wire logic        i_no_station_found_flag,
    input  wire logic        i_polling_timeout_flag,
    input  wire logic        i_station_fail_flag,
    input  wire logic        i_length_overrun_flag,
    input  wire logic        i_hotswap_recovery_fail_flag,
    input  wire logic        i_network_init_fail_flag,
    input  wire logic        i_address_range_fault_flag,
    input  wire logic        i_slot_timeout_evt,
    input  wire logic [5:0]  i_slot_timeout_id,
    input  wire logic [6:0]  i_module_count,
    input  wire logic        i_config_done,
    output logic             o_errmod_placed,
    output logic      [6:0]  o_errmod_first_slot
);

    // ********************************************************
    // button synchroniser and press classifier
    // ********************************************************
    logic                      key_meta_r;
    logic                      key_sync_r;
    cesrk_pkg::cesrk_key_type  state_r;
    cesrk_pkg::cesrk_key_type  state_nxt;
    logic [30:0]               press_cnt_r;
    logic [30:0]               press_cnt_nxt;
    logic [30:0]               flash_cnt_r;
    logic [30:0]               flash_cnt_nxt;
    logic [7:0]                flash_tog_r;
    logic [7:0]                flash_tog_nxt;
    logic                      red_r;
    logic                      red_nxt;
    logic                      restart_nxt;
    logic                      restore_nxt;
    wire                       pressed = ~key_sync_r;
    wire  [30:0]               long_last = 31'(LONG_PRESS_CYC - 1);
    wire  [30:0]               half_last = 31'(FLASH_HALF_CYC - 1);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            key_meta_r <= 1'b1;
            key_sync_r <= 1'b1;
        end else begin
            key_meta_r <= i_reset_key_b;
            key_sync_r <= key_meta_r;
        end
    end

    // a press during the flash sequence is ignored until it ends
    always_comb begin
        state_nxt     = state_r;
        press_cnt_nxt = press_cnt_r;
        flash_cnt_nxt = flash_cnt_r;
        flash_tog_nxt = flash_tog_r;
        red_nxt       = red_r;
        restart_nxt   = 1'b0;
        restore_nxt   = 1'b0;
        case (state_r)
            cesrk_pkg::KEY_IDLE: begin
                red_nxt = 1'b0;
                if (pressed) begin
                    state_nxt     = cesrk_pkg::KEY_SHORT;
                    press_cnt_nxt = 31'h0000_0001;
                end
            end
            cesrk_pkg::KEY_SHORT: begin
                if (!pressed) begin
                    state_nxt   = cesrk_pkg::KEY_IDLE;
                    restart_nxt = 1'b1; // see RULE1
                end else if (press_cnt_r >= long_last) begin
                    state_nxt = cesrk_pkg::KEY_LONG; // see RULE1
                    red_nxt   = 1'b1; // see RULE2
                end else begin
                    press_cnt_nxt = press_cnt_r + 31'h0000_0001;
                end
            end
            cesrk_pkg::KEY_LONG: begin
                red_nxt = 1'b1; // see RULE2
                if (!pressed) begin
                    state_nxt     = cesrk_pkg::KEY_FLASH;
                    restore_nxt   = 1'b1; // see RULE1
                    flash_cnt_nxt = 31'h0000_0000;
                    flash_tog_nxt = 8'h00;
                    red_nxt       = 1'b0;
                end
            end
            cesrk_pkg::KEY_FLASH: begin
                if (flash_cnt_r >= half_last) begin
                    flash_cnt_nxt = 31'h0000_0000;
                    red_nxt       = ~red_r; // see RULE3
                    flash_tog_nxt = flash_tog_r + 8'h01;
                    if (flash_tog_r >= cesrk_pkg::FLASH_TOGGLES - 8'h01) begin
                        state_nxt = cesrk_pkg::KEY_IDLE;
                        red_nxt   = 1'b0;
                    end
                end else begin
                    flash_cnt_nxt = flash_cnt_r + 31'h0000_0001;
                end
            end
            default: begin
                state_nxt = cesrk_pkg::KEY_IDLE;
            end
        endcase
    end

    wire ind_red_nxt   = (state_nxt == cesrk_pkg::KEY_IDLE) ? i_sys_red_normal : red_nxt;
    wire ind_green_nxt = (state_nxt == cesrk_pkg::KEY_IDLE) ? i_sys_green_normal : 1'b0;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r                  <= cesrk_pkg::KEY_IDLE;
            press_cnt_r              <= 31'h0000_0000;
            flash_cnt_r              <= 31'h0000_0000;
            flash_tog_r              <= 8'h00;
            red_r                    <= 1'b0;
            o_module_restart         <= 1'b0;
            o_restore_defaults       <= 1'b0;
            o_system_indicator_red   <= 1'b0;
            o_system_indicator_green <= 1'b0;
        end else begin
            state_r                  <= state_nxt;
            press_cnt_r              <= press_cnt_nxt;
            flash_cnt_r              <= flash_cnt_nxt;
            flash_tog_r              <= flash_tog_nxt;
            red_r                    <= red_nxt;
            o_module_restart         <= restart_nxt;
            o_restore_defaults       <= restore_nxt;
            o_system_indicator_red   <= ind_red_nxt;
            o_system_indicator_green <= ind_green_nxt;
        end
    end

    // ********************************************************
    // error module placement
    // ********************************************************
    wire [6:0] count_eff = (i_module_count > cesrk_pkg::MAX_MODULES) ?
                           cesrk_pkg::MAX_MODULES : i_module_count; // see RULE22
    wire       room_ok   = (count_eff <= cesrk_pkg::ERRMOD_LAST_OK);
    logic [6:0] count_r;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_errmod_placed     <= 1'b0;
            o_errmod_first_slot <= 7'h00;
            count_r             <= 7'h00;
        end else if (i_config_done) begin
            count_r             <= count_eff;
            o_errmod_placed     <= room_ok; // see RULE4
            o_errmod_first_slot <= room_ok ? count_eff + 7'h01 : 7'h00; // see RULE5
        end
    end

    // ********************************************************
    // wishbone slave, one wait state
    // ********************************************************
    wire        wb_req   = i_wb_cyc & i_wb_stb;
    wire        wb_wr    = wb_req & i_wb_we & o_wb_ack;
    wire [31:0] byte_msk = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                            {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire [31:0] wr_bits  = i_wb_dat & byte_msk;
    wire [31:0] clr_sys  = (wb_wr && i_wb_adr == cesrk_pkg::OFS_CLR_SYS)  ? wr_bits : 32'h0;
    wire [31:0] clr_low  = (wb_wr && i_wb_adr == cesrk_pkg::OFS_CLR_LOW)  ? wr_bits : 32'h0;
    wire [31:0] clr_high = (wb_wr && i_wb_adr == cesrk_pkg::OFS_CLR_HIGH) ? wr_bits : 32'h0;

    logic [31:0] sys_r;
    logic [31:0] map_lo_r;
    logic [31:0] map_hi_r;
    logic [31:0] status_w;
    logic [31:0] rd_mux;

    always_comb begin
        status_w = 32'h0;
        status_w[cesrk_pkg::STAT_PLACED_BIT] = o_errmod_placed;
        status_w[cesrk_pkg::STAT_SLOT_LSB +: 7]  = o_errmod_first_slot;
        status_w[cesrk_pkg::STAT_COUNT_LSB +: 7] = count_r;
        status_w[cesrk_pkg::STAT_KEY_LSB +: 2]   = state_r;
    end

    // unmapped and clear offsets read zero; reading never touches a flag
    assign rd_mux = (i_wb_adr == cesrk_pkg::OFS_SYS_FLAGS) ? sys_r :
                    (i_wb_adr == cesrk_pkg::OFS_MAP_LOW)   ? map_lo_r :
                    (i_wb_adr == cesrk_pkg::OFS_MAP_HIGH)  ? map_hi_r :
                    (i_wb_adr == cesrk_pkg::OFS_STATUS)    ? status_w : 32'h0; // see RULE23

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_req & ~o_wb_ack;
            if (wb_req && !o_wb_ack) begin
                o_wb_dat <= i_wb_we ? 32'h0 : rd_mux;
            end
        end
    end

    // ********************************************************
    // sticky fault flags, set wins over clear
    // ********************************************************
    logic [31:0] sys_set;
    logic [63:0] slot_set;
    wire         slot_ok = i_slot_timeout_evt && ({1'b0, i_slot_timeout_id} < count_eff);

    always_comb begin
        sys_set = 32'h0;
        sys_set[cesrk_pkg::BIT_FIRST_BOOT] = i_first_boot_flag; // see RULE7
        sys_set[cesrk_pkg::BIT_MEM_OVER]   = i_memory_oversize_flag; // see RULE8
        sys_set[cesrk_pkg::BIT_CHECKSUM]   = i_checksum_fault_flag; // see RULE9
        sys_set[cesrk_pkg::BIT_BOOT_FAIL]  = i_boot_fail_flag; // see RULE10
        sys_set[cesrk_pkg::BIT_LOAD_PWR]   = i_load_power_missing_flag; // see RULE11
        sys_set[cesrk_pkg::BIT_OVERLOAD]   = i_overload_flag; // see RULE11
        sys_set[cesrk_pkg::BIT_CONV_READ]  = i_converter_read_fault_flag; // see RULE11
        sys_set[cesrk_pkg::BIT_MEM_PROG]   = i_memory_program_fail_flag; // see RULE12
        sys_set[cesrk_pkg::BIT_NO_RECORD]  = i_no_station_record_flag; // see RULE13
        sys_set[cesrk_pkg::BIT_REC_DIFF]   = i_station_record_mismatch_flag; // see RULE13
        sys_set[cesrk_pkg::BIT_NO_STATION] = i_no_station_found_flag; // see RULE13
        sys_set[cesrk_pkg::BIT_POLL_TOUT]  = i_polling_timeout_flag | slot_ok; // see RULE14
        sys_set[cesrk_pkg::BIT_STN_FAIL]   = i_station_fail_flag; // see RULE15
        sys_set[cesrk_pkg::BIT_LEN_OVER]   = i_length_overrun_flag; // see RULE16
        sys_set[cesrk_pkg::BIT_HOTSWAP]    = i_hotswap_recovery_fail_flag; // see RULE17
        sys_set[cesrk_pkg::BIT_NET_INIT]   = i_network_init_fail_flag; // see RULE18
        sys_set[cesrk_pkg::BIT_ADR_RANGE]  = i_address_range_fault_flag; // see RULE19
    end

    // ids past the physical stack are dropped, a stale poller cannot mark them
    assign slot_set = slot_ok ? (64'h1 << i_slot_timeout_id) : 64'h0; // see RULE22

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_flag
            always_ff @(posedge i_core_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    sys_r[gi]    <= cesrk_pkg::FLAGS_RESET[gi];
                    map_lo_r[gi] <= cesrk_pkg::FLAGS_RESET[gi];
                    map_hi_r[gi] <= cesrk_pkg::FLAGS_RESET[gi];
                end else begin
                    sys_r[gi]    <= cesrk_pkg::SYS_VALID_MASK[gi] &
                                    (sys_set[gi] | (sys_r[gi] & ~clr_sys[gi])); // see RULE6
                    map_lo_r[gi] <= slot_set[gi] | (map_lo_r[gi] & ~clr_low[gi]); // see RULE20
                    map_hi_r[gi] <= slot_set[gi+32] | (map_hi_r[gi] & ~clr_high[gi]); // see RULE21
                end
            end
        end
    endgenerate

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    short_press_restart_a: assert property ( // see RULE1
        state_r == cesrk_pkg::KEY_SHORT && !pressed |=>
            o_module_restart && !o_restore_defaults && state_r == cesrk_pkg::KEY_IDLE)
        else $error("short press did not restart");

    long_press_entry_a: assert property ( // see RULE1
        state_r == cesrk_pkg::KEY_SHORT && pressed && press_cnt_r == long_last |=>
            state_r == cesrk_pkg::KEY_LONG && o_system_indicator_red)
        else $error("long press not recognised at its count");

    long_hold_red_a: assert property ( // see RULE2
        state_r == cesrk_pkg::KEY_LONG && $past(state_r) == cesrk_pkg::KEY_LONG |->
            o_system_indicator_red && !o_system_indicator_green)
        else $error("indicator not steady red during long hold");

    release_flash_a: assert property ( // see RULE3
        state_r == cesrk_pkg::KEY_LONG && !pressed |=>
            o_restore_defaults && state_r == cesrk_pkg::KEY_FLASH ##1 !o_restore_defaults)
        else $error("release after long press did not restore and flash");

    flash_toggle_a: assert property ( // see RULE3
        state_r == cesrk_pkg::KEY_FLASH && flash_cnt_r == half_last &&
        flash_tog_r < cesrk_pkg::FLASH_TOGGLES - 8'h01 |=> $changed(o_system_indicator_red))
        else $error("flash indicator did not toggle");

    place_ok_a: assert property ( // see RULE4
        i_config_done && room_ok |=>
            o_errmod_placed && o_errmod_first_slot == $past(count_eff) + 7'h01)
        else $error("error module not placed after last module");

    place_skip_a: assert property ( // see RULE5
        i_config_done && !room_ok |=> !o_errmod_placed && o_errmod_first_slot == 7'h00)
        else $error("error module placed without room");

    reserved_zero_a: assert property ( // see RULE6
        (sys_r & ~cesrk_pkg::SYS_VALID_MASK) == 32'h0)
        else $error("reserved system bit set");

    first_boot_set_a: assert property ( // see RULE7
        i_first_boot_flag |=> sys_r[cesrk_pkg::BIT_FIRST_BOOT] [*2])
        else $error("first boot flag lost");

    slot_low_set_a: assert property ( // see RULE20
        slot_ok && !i_slot_timeout_id[5] |=>
            map_lo_r[$past(i_slot_timeout_id[4:0])] && sys_r[cesrk_pkg::BIT_POLL_TOUT])
        else $error("low slot timeout not recorded");

    slot_high_set_a: assert property ( // see RULE21
        slot_ok && i_slot_timeout_id[5] |=> map_hi_r[$past(i_slot_timeout_id[4:0])])
        else $error("high slot timeout not recorded");

    slot_range_a: assert property ( // see RULE22
        i_slot_timeout_evt && !slot_ok && !(|clr_low) |=> $stable(map_lo_r))
        else $error("timeout beyond stack recorded");

    read_no_effect_a: assert property ( // see RULE23
        o_wb_ack && !i_wb_we && !(|sys_set) |=> $stable(sys_r))
        else $error("read changed system flags");

    bus_ack_a: assert property (
        wb_req && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("wishbone answer not one cycle");

    short_press_c: cover property (state_r == cesrk_pkg::KEY_SHORT && !pressed);
    long_press_c:  cover property (state_r == cesrk_pkg::KEY_FLASH && flash_tog_r == 8'h01);
    place_skip_c:  cover property (i_config_done && !room_ok);
    slot_hit_c:    cover property (slot_ok && i_slot_timeout_id[5]);

endmodule
